// file: rtl/admu_pkg.sv
// Package for the ADC DC measurement unit: register map, field layout and carriers.
// Assumes a classic Wishbone slave with 8-bit register indices and 32-bit data.
package admu_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_GAIN    = 8'h5D;
  localparam logic [7:0] IDX_RSVD_LO = 8'h5E;
  localparam logic [7:0] IDX_RSVD_HI = 8'h65;
  localparam logic [7:0] IDX_CTL1    = 8'h66;
  localparam logic [7:0] IDX_CTL2    = 8'h67;
  localparam logic [7:0] IDX_OUT_HI  = 8'h68;
  localparam logic [7:0] IDX_OUT_MID = 8'h69;
  localparam logic [7:0] IDX_OUT_LO  = 8'h6A;

  // ---------------------------------------------------------------------------
  // Field positions and limits
  // ---------------------------------------------------------------------------
  localparam int         CTL1_EN_BIT   = 7;
  localparam int         CTL1_IIR_BIT  = 5;
  localparam int         CTL2_HOLD_BIT = 6;
  localparam int         CTL2_SNAP_BIT = 5;
  localparam logic [4:0] EXP_MIN       = 5'h01;
  localparam logic [4:0] EXP_MAX       = 5'h14;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [23:0] RESULT_RESET = 24'h000000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       iir_sel;
    logic       hold;
    logic       snap_mode;
    logic [4:0] exponent;
    logic [4:0] avg_time;
  } admu_cfg_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } admu_result_s;

endpackage : admu_pkg

// file: rtl/admu_filter.sv
// Filter core: sinc1 averager or first-order IIR over signed ADC samples.
// Assumes samples arrive as one-cycle strobes on the same clock.
`timescale 1ns/100ps
module admu_filter #(
  parameter int SW = 24
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire admu_pkg::admu_cfg_s   cfg_i,
  input  wire logic                  smp_vld_i,
  input  wire logic signed [SW-1:0]  smp_i,
  output admu_pkg::admu_result_s     res_o
);

  typedef struct packed {
    logic signed [SW+20:0] acc;
    logic [20:0]           cnt;
    logic [20:0]           tcnt;
    admu_pkg::admu_result_s res;
  } admu_flt_s;

  admu_flt_s r;
  admu_flt_s next_r;
  logic [20:0] n_samp;
  logic [20:0] n_time;
  logic signed [SW+20:0] sext;

  assign n_samp = 21'h000001 << cfg_i.exponent;
  assign n_time = 21'h000001 << cfg_i.avg_time;
  assign sext   = {{21{smp_i[SW-1]}}, smp_i};
  assign res_o  = r.res;

  always_comb
  begin
    next_r = r;
    next_r.res.valid = 1'b0;
    if (!cfg_i.enable)
    begin
      next_r.acc  = '0;
      next_r.cnt  = '0;
      next_r.tcnt = '0;
    end
    else if (smp_vld_i)
    begin
      if (!cfg_i.iir_sel)
      begin
        // Sinc averager: sum 2^D samples, then shift down by D.
        next_r.acc = r.acc + sext;
        next_r.cnt = r.cnt + 21'h000001;
        if (next_r.cnt == n_samp)
        begin
          next_r.res.value = 24'(next_r.acc >>> cfg_i.exponent);
          next_r.res.valid = 1'b1;
          next_r.acc = '0;
          next_r.cnt = '0;
        end
      end
      else
      begin
        // IIR: y += (x - y) / 2^D, the state held with D fraction bits.
        next_r.acc = r.acc + sext - (r.acc >>> cfg_i.exponent);
        next_r.res.value = 24'(next_r.acc >>> cfg_i.exponent);
        next_r.res.valid = !cfg_i.snap_mode;
        next_r.tcnt = r.tcnt + 21'h000001;
        if (cfg_i.avg_time != 5'h00 && next_r.tcnt == n_time)
        begin
          // Periodic clear; snapshot mode reports the value just before it.
          next_r.res.valid = cfg_i.snap_mode;
          next_r.acc  = '0;
          next_r.tcnt = '0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  property p_sinc_period;
    @(posedge clock_i) disable iff (!rst_n_i)
      (cfg_i.enable && !cfg_i.iir_sel && r.cnt != '0) |-> (r.cnt <= n_samp);
  endproperty
  a_sinc_period: assert property (p_sinc_period) else $error("sinc counter passed window");

  property p_time_window;
    @(posedge clock_i) disable iff (!rst_n_i)
      (cfg_i.enable && cfg_i.iir_sel && cfg_i.avg_time != 5'h00) |-> (r.tcnt < n_time);
  endproperty
  a_time_window: assert property (p_time_window) else $error("IIR clear period exceeded");

endmodule : admu_filter

// file: rtl/admu_top.sv
// Top of the ADC DC measurement unit with its Wishbone register slave.
// Assumes samples and gain come from logic on the same 200 MHz clock.
// Assumes the bus master waits for ack and drops its strobe for a cycle between requests.
// The result is only as coherent as software makes it: freeze first, read three bytes, release.
// Only bit 0 of the byte select matters, since every register is one byte wide.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
module admu_top #(
  parameter int SW = 24
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [9:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 smp_vld_i,
  input  wire logic signed [SW-1:0] smp_i,
  input  wire logic [7:0]           agc_gain_i,
  output logic                      meas_en_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    logic [23:0] result;
    logic [31:0] dat;
    logic        ack;
    logic        en;
  } admu_top_s;

  admu_top_s r;
  admu_top_s next_r;
  admu_pkg::admu_cfg_s    cfg;
  admu_pkg::admu_result_s fres;
  logic [7:0] idx;
  logic       req;
  logic [7:0] rdata;
  logic [7:0] wbyte;

  assign idx   = wb_adr_i[9:2];
  assign req   = wb_cyc_i && wb_stb_i && !r.ack;
  assign wbyte = wb_dat_i[7:0];

  assign cfg.enable    = r.ctl1[admu_pkg::CTL1_EN_BIT];
  assign cfg.iir_sel   = r.ctl1[admu_pkg::CTL1_IIR_BIT];
  assign cfg.exponent  = r.ctl1[4:0];
  assign cfg.hold      = r.ctl2[admu_pkg::CTL2_HOLD_BIT];
  assign cfg.snap_mode = r.ctl2[admu_pkg::CTL2_SNAP_BIT];
  assign cfg.avg_time  = r.ctl2[4:0];

  admu_filter #(
    .SW(SW)
  ) u_filter (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .cfg_i    (cfg),
    .smp_vld_i(smp_vld_i),
    .smp_i    (smp_i),
    .res_o    (fres)
  );

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rdata = 8'h00;
    unique case (idx)
      admu_pkg::IDX_GAIN:    rdata = agc_gain_i;
      admu_pkg::IDX_CTL1:    rdata = r.ctl1;
      admu_pkg::IDX_CTL2:    rdata = r.ctl2;
      admu_pkg::IDX_OUT_HI:  rdata = r.result[23:16];
      admu_pkg::IDX_OUT_MID: rdata = r.result[15:8];
      admu_pkg::IDX_OUT_LO:  rdata = r.result[7:0];
      default:               rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.ack = req;
    next_r.en  = cfg.enable;
    // Reads only load the data latch and raise ack; no control state moves on a read.
    if (req && !wb_we_i)
      next_r.dat = {24'h000000, rdata};
    if (req && wb_we_i && wb_sel_i[0])
    begin
      // Reserved bits are stored as written; software keeps them zero.
      if (idx == admu_pkg::IDX_CTL1)
        next_r.ctl1 = wbyte;
      if (idx == admu_pkg::IDX_CTL2)
        next_r.ctl2 = wbyte;
    end
    // Frozen results let the three bytes be read coherently.
    if (fres.valid && !cfg.hold)
      next_r.result = fres.value;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r.ctl1   <= admu_pkg::CTL_RESET;
      r.ctl2   <= admu_pkg::CTL_RESET;
      r.result <= admu_pkg::RESULT_RESET;
      r.dat    <= 32'h00000000;
      r.ack    <= 1'b0;
      r.en     <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign wb_dat_o  = r.dat;
  assign wb_ack_o  = r.ack;
  assign meas_en_o = r.en;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_hold_freeze;
    @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.hold && $past(cfg.hold)) |-> $stable(r.result);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("result moved while held");

  property p_enable_reset;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !cfg.enable;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable set after reset");

  property p_out_hi;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_OUT_HI) |=> (wb_dat_o[7:0] == $past(r.result[23:16]));
  endproperty
  a_out_hi: assert property (p_out_hi) else $error("high result byte wrong");

  property p_out_lo;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_OUT_LO) |=> (wb_dat_o[7:0] == $past(r.result[7:0]));
  endproperty
  a_out_lo: assert property (p_out_lo) else $error("low result byte wrong");

  property p_gain;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_GAIN) |=> (wb_dat_o[7:0] == $past(agc_gain_i));
  endproperty
  a_gain: assert property (p_gain) else $error("gain readback wrong");

  property p_read_quiet;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i) |=> (r.ctl1 == $past(r.ctl1) && r.ctl2 == $past(r.ctl2));
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed control state");

  property p_ack_one;
    @(posedge clock_i) disable iff (!rst_n_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_exp_legal;
    @(posedge clock_i) disable iff (!rst_n_i)
      cfg.enable |->
        (cfg.exponent >= admu_pkg::EXP_MIN && cfg.exponent <= admu_pkg::EXP_MAX);
  endproperty
  a_exp_legal: assert property (p_exp_legal) else $error("reserved exponent in use");

  // ---------------------------------------------------------------------------
  // Bus checks
  // ---------------------------------------------------------------------------

  // The enable output trails the control bit by exactly one cycle.
  property p_en_mirror;
    @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |=>
        (meas_en_o == $past(cfg.enable));
  endproperty
  a_en_mirror: assert property (p_en_mirror) else $error("enable output does not follow control");

  // A write with the low byte selected lands in control one.
  property p_ctl1_write;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && wb_we_i && wb_sel_i[0] && idx == admu_pkg::IDX_CTL1) |=>
        (r.ctl1 == $past(wb_dat_i[7:0]));
  endproperty
  a_ctl1_write: assert property (p_ctl1_write) else $error("control one write lost");

  // A write with the low byte selected lands in control two.
  property p_ctl2_write;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && wb_we_i && wb_sel_i[0] && idx == admu_pkg::IDX_CTL2) |=>
        (r.ctl2 == $past(wb_dat_i[7:0]));
  endproperty
  a_ctl2_write: assert property (p_ctl2_write) else $error("control two write lost");

  // Control one reads back as stored.
  property p_ctl1_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_CTL1) |=>
        (wb_dat_o[7:0] == $past(r.ctl1));
  endproperty
  a_ctl1_read: assert property (p_ctl1_read) else $error("control one readback wrong");

  // Control two reads back as stored.
  property p_ctl2_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_CTL2) |=>
        (wb_dat_o[7:0] == $past(r.ctl2));
  endproperty
  a_ctl2_read: assert property (p_ctl2_read) else $error("control two readback wrong");

  // The reserved window holds no storage, so it always reads as zero.
  property p_rsvd_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx >= admu_pkg::IDX_RSVD_LO && idx <= admu_pkg::IDX_RSVD_HI) |=>
        (wb_dat_o == 32'h00000000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register read not zero");

  // Registers are one byte wide; the upper lanes never carry data.
  property p_dat_upper;
    @(posedge clock_i) disable iff (!rst_n_i)
      wb_ack_o |->
        (wb_dat_o[31:8] == 24'h000000);
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper read lanes not zero");

  // Every taken request is answered in the next cycle.
  property p_ack_follows;
    @(posedge clock_i) disable iff (!rst_n_i)
      req |=>
        wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not answered");

  // No answer appears without a request taken the cycle before.
  property p_no_spurious_ack;
    @(posedge clock_i) disable iff (!rst_n_i)
      !req |=>
        !wb_ack_o;
  endproperty
  a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("ack without request");

  // Control registers move only on a write.
  property p_ctl_quiet;
    @(posedge clock_i) disable iff (!rst_n_i)
      !(req && wb_we_i) |=>
        ($stable(r.ctl1) && $stable(r.ctl2));
  endproperty
  a_ctl_quiet: assert property (p_ctl_quiet) else $error("control changed without write");

  // ---------------------------------------------------------------------------
  // Result and filter checks
  // ---------------------------------------------------------------------------

  // The first cycle out of reset shows cleared outputs.
  property p_reset_result;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |->
        (r.result == admu_pkg::RESULT_RESET && wb_dat_o == 32'h00000000 && !wb_ack_o);
  endproperty
  a_reset_result: assert property (p_reset_result) else $error("result not clear after reset");

  // The middle result byte reads back the stored bits.
  property p_out_mid;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && idx == admu_pkg::IDX_OUT_MID) |=>
        (wb_dat_o[7:0] == $past(r.result[15:8]));
  endproperty
  a_out_mid: assert property (p_out_mid) else $error("middle result byte wrong");

  // While updates run, each filter result is taken at once.
  property p_result_update;
    @(posedge clock_i) disable iff (!rst_n_i)
      (fres.valid && !cfg.hold) |=>
        (r.result == $past(fres.value));
  endproperty
  a_result_update: assert property (p_result_update) else $error("filter result not taken");

  // A hold seen at an edge keeps the result of that edge.
  property p_result_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      cfg.hold |=>
        (r.result == $past(r.result));
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result updated while frozen");

  // A read leaves the result alone unless the filter delivers.
  property p_read_keeps_result;
    @(posedge clock_i) disable iff (!rst_n_i)
      (req && !wb_we_i && !(fres.valid && !cfg.hold)) |=>
        $stable(r.result);
  endproperty
  a_read_keeps_result: assert property (p_read_keeps_result) else $error("read moved the result");

  // A disabled unit produces no results.
  property p_disabled_no_valid;
    @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.enable |=>
        !fres.valid;
  endproperty
  a_disabled_no_valid: assert property (p_disabled_no_valid) else $error("result while disabled");

  // Results only follow a sample strobe.
  property p_no_sample_no_valid;
    @(posedge clock_i) disable iff (!rst_n_i)
      !smp_vld_i |=>
        !fres.valid;
  endproperty
  a_no_sample_no_valid: assert property (p_no_sample_no_valid) else $error("result without sample");

  c_sinc_result: cover property (@(posedge clock_i) fres.valid && !cfg.iir_sel);
  c_iir_live:    cover property (@(posedge clock_i) fres.valid && cfg.iir_sel && !cfg.snap_mode);
  c_ctl_write:   cover property (@(posedge clock_i) req && wb_we_i && idx == admu_pkg::IDX_CTL1);
  c_iir_snap:    cover property (@(posedge clock_i) fres.valid && cfg.iir_sel && cfg.snap_mode);
  c_held_read:   cover property (@(posedge clock_i) cfg.hold && req && idx == admu_pkg::IDX_OUT_MID);

endmodule : admu_top

// file: tb/testbench.sv
// Self-checking bench for the DC measurement unit and its register slave.
// Assumes the slave answers one cycle after taking a request, as handed over.
`timescale 1ns/100ps
module testbench;
  logic               clock_i    = 1'b0;
  logic               rst_n      = 1'b0;
  logic               cyc        = 1'b0;
  logic               stb        = 1'b0;
  logic               we         = 1'b0;
  logic [9:0]         adr        = 10'h000;
  logic [3:0]         sel        = 4'h0;
  logic [31:0]        dat        = 32'h00000000;
  logic               smp_vld    = 1'b0;
  logic signed [23:0] smp        = 24'h000000;
  logic [7:0]         gain       = 8'h00;
  logic [31:0]        rdat;
  logic               ack;
  logic               meas_en;
  logic [31:0]        rd;
  logic [7:0]         g;
  int                 err_count  = 0;
  int                 n_compared = 0;
  int                 cycles     = 0;
  int                 acc;
  int                 sum;
  int                 x;
  int                 snap;

  always #2.5 clock_i = ~clock_i;

  admu_top i_admu_top (.clock_i(clock_i), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .smp_vld_i(smp_vld),
    .smp_i(smp), .agc_gain_i(gain), .meas_en_o(meas_en));

  // ---------------------------------------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------------------------------------
  task automatic stop_test;
    $display("Counts: %0d compared, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, wd};
    @(posedge clock_i);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clock_i);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk({31'h0, ack}, 32'h1, "bus ack");
  endtask : wb

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp}, what);
  endtask : rd_chk

  task automatic send(input int v);
    @(posedge clock_i);
    smp_vld <= 1'b1;
    smp     <= v[23:0];
    @(posedge clock_i);
    smp_vld <= 1'b0;
  endtask : send

  // Freezing first keeps the three bytes coherent while they are read.
  task automatic res_chk(input int exp, input logic [7:0] ctl2);
    logic [23:0] e;
    e = exp[23:0];
    repeat (4) @(posedge clock_i);
    wb(1'b1, admu_pkg::IDX_CTL2, ctl2 | 8'h40);
    rd_chk(admu_pkg::IDX_OUT_HI, e[23:16], "result high");
    rd_chk(admu_pkg::IDX_OUT_MID, e[15:8], "result middle");
    rd_chk(admu_pkg::IDX_OUT_LO, e[7:0], "result low");
    wb(1'b1, admu_pkg::IDX_CTL2, ctl2);
  endtask : res_chk

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    void'($urandom(82658));
    repeat (4) @(posedge clock_i);
    rst_n <= 1'b1;
    rd_chk(admu_pkg::IDX_CTL1, 8'h00, "control one");
    rd_chk(admu_pkg::IDX_CTL2, 8'h00, "control two");
    res_chk(0, 8'h00);
    chk({31'h0, meas_en}, 32'h0, "enable");
    $display("Test reset done");
    for (int i = 0; i < 6; i++)
    begin
      g = (i == 0) ? 8'hE8 : (i == 1) ? 8'h77 : (i == 2) ? 8'h00 : 8'($urandom_range(0, 255));
      gain <= g;
      rd_chk(admu_pkg::IDX_GAIN, g, "gain");
      rd_chk(admu_pkg::IDX_GAIN, g, "gain again");
    end
    wb(1'b1, admu_pkg::IDX_GAIN, 8'h55);
    rd_chk(admu_pkg::IDX_GAIN, g, "gain after write");
    wb(1'b1, admu_pkg::IDX_OUT_HI, 8'hFF);
    rd_chk(admu_pkg::IDX_OUT_HI, 8'h00, "result after write");
    rd_chk(admu_pkg::IDX_RSVD_LO, 8'h00, "reserved read");
    $display("Test registers done");
    for (int d = 1; d <= 3; d += 2)
    begin
      wb(1'b1, admu_pkg::IDX_CTL1, 8'h80 | d[7:0]);
      rd_chk(admu_pkg::IDX_CTL1, 8'h80 | d[7:0], "control one");
      repeat (2) @(posedge clock_i);
      chk({31'h0, meas_en}, 32'h1, "enable");
      sum = 0;
      repeat (1 << d)
      begin
        x = int'($urandom_range(0, 4000)) - 2000;
        sum += x;
        send(x);
      end
      res_chk(sum >>> d, 8'h00);
      wb(1'b1, admu_pkg::IDX_CTL2, 8'h40);
      repeat (1 << d) send(1000);
      res_chk(sum >>> d, 8'h40);
      wb(1'b1, admu_pkg::IDX_CTL2, 8'h00);
      wb(1'b1, admu_pkg::IDX_CTL1, 8'h00);
      repeat (2) @(posedge clock_i);
      chk({31'h0, meas_en}, 32'h0, "enable");
    end
    $display("Test sinc done");
    wb(1'b1, admu_pkg::IDX_CTL1, 8'hA2);
    acc = 0;
    for (int i = 0; i < 6; i++)
    begin
      x = int'($urandom_range(0, 4000)) - 2000;
      acc = acc + x - (acc >>> 2);
      send(x);
      if (i % 3 == 2)
        res_chk(acc >>> 2, 8'h00);
    end
    wb(1'b1, admu_pkg::IDX_CTL1, 8'h00);
    wb(1'b1, admu_pkg::IDX_CTL2, 8'h22);
    wb(1'b1, admu_pkg::IDX_CTL1, 8'hA2);
    acc = 0;
    for (int i = 1; i <= 8; i++)
    begin
      x = int'($urandom_range(0, 4000)) - 2000;
      acc = acc + x - (acc >>> 2);
      send(x);
      if (i % 4 == 0)
      begin
        snap = acc >>> 2;
        acc = 0;
      end
    end
    res_chk(snap, 8'h22);
    $display("Test iir done");
    stop_test;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("Error at %0t: run took too long", $time);
      stop_test;
    end
  end
endmodule : testbench
